// File: core/pxc_ext_bank.sv
// Functional notes
// - registers 0x18 to 0x1a are fully reserved
// - bit 15 disables crossover in forced 10/100
// - half duplex carrier from rx valid, tx enable, or rx valid alone when bit 13 set
// - full duplex carrier is rx valid or zero
// - bit 11 reads eeprom detected
// - bit 9 enables reduced power mode
// - 100M amplitude field, reset 110, 011 reserved
// - gigabit amplitude field, reset 000, 011 reserved
// - gigabit edge rate field, reset 111
// - rgmii tx/rx skew fields reset from straps
// - max packet length field, four sizes
// - bit 9 allows 10M reception without preamble
module pxc_ext_bank
  import pxc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [4:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic [15:0]      regRdData_r,
  // phy status and straps
  input  wire logic        eepromDetected,
  input  wire logic [1:0]  strapSkew,
  input  wire logic        fullDuplex,
  // mac side
  input  wire logic        rxValid,
  input  wire logic        txEnable,
  output logic             carrierSense_r,
  // controls to the phy core
  output logic             xoverDisable_r,
  output logic             lowPowerEn_r,
  output logic [2:0]       amp100_r,
  output logic [2:0]       amp1g_r,
  output logic [2:0]       edgeRate_r,
  output logic [1:0]       txSkew_r,
  output logic [1:0]       rxSkew_r,
  output logic [1:0]       maxLenSel_r,
  output logic             noPreamble_r,
  output logic             farLoopback_r
);
  // =====================================================================
  // state
  logic [15:0] ctrlFive_r,  ctrlFive_nxt;
  logic [15:0] skewFrame_r, skewFrame_nxt;
  logic        strapLoad_r, strapLoad_nxt;
  logic [15:0] rdData_nxt;
  logic        eepSeen_r,   eepSeen_nxt;
  logic        crsNxt;

  function automatic logic [15:0] merge(input logic [15:0] oldV,
                                        input logic [15:0] newV,
                                        input logic [15:0] mask);
    merge = (oldV & ~mask) | (newV & mask);
  endfunction

  // =====================================================================
  // register next values
  always_comb begin
    ctrlFive_nxt  = ctrlFive_r;
    skewFrame_nxt = skewFrame_r;
    strapLoad_nxt = 1'b0;
    eepSeen_nxt   = eepromDetected;
    // straps sampled on the first edge after release, never under reset
    if (strapLoad_r) begin
      skewFrame_nxt[SK_TX_LSB +: 2] = strapSkew;
      skewFrame_nxt[SK_RX_LSB +: 2] = strapSkew;
    end
    if (regWrEn && regAddr == REG_CTRL_FIVE) begin
      ctrlFive_nxt = merge(ctrlFive_r, regWrData, CF_RW_MASK);
      // reserved amplitude codes are refused, field keeps its value
      if (regWrData[CF_AMP100_LSB +: 3] == AMP_RESERVED) begin
        ctrlFive_nxt[CF_AMP100_LSB +: 3] = ctrlFive_r[CF_AMP100_LSB +: 3];
      end
      if (regWrData[CF_AMP1G_LSB +: 3] == AMP_RESERVED) begin
        ctrlFive_nxt[CF_AMP1G_LSB +: 3] = ctrlFive_r[CF_AMP1G_LSB +: 3];
      end
    end
    if (regWrEn && regAddr == REG_SKEW_FRAME) begin
      skewFrame_nxt = merge(skewFrame_r, regWrData, SK_RW_MASK);
    end
    // soft reset: only the non-sticky far loopback bit returns to zero
    if (regWrEn && regAddr == REG_STRAP_SEL && regWrData[SR_SOFT_BIT]) begin
      ctrlFive_nxt[CF_FARLB_BIT] = 1'b0;
    end
  end

  // =====================================================================
  // read path; reserved words and bits read zero
  always_comb begin
    rdData_nxt = 16'h0000;
    if (regRdEn) begin
      unique case (regAddr)
        REG_CTRL_FIVE: begin
          rdData_nxt = ctrlFive_r & CF_RW_MASK;
          rdData_nxt[CF_EEP_BIT] = eepSeen_r;
        end
        REG_SKEW_FRAME: rdData_nxt = skewFrame_r & SK_RW_MASK;
        default:        rdData_nxt = 16'h0000;
      endcase
    end
  end

  pxc_crs_mux u_crs (
    .rxValid    (rxValid),
    .txEnable   (txEnable),
    .fullDuplex (fullDuplex),
    .crsCtrl    (ctrlFive_r[CF_CRS_LSB +: 2]),
    .crsNxt     (crsNxt)
  );

  // =====================================================================
  // registers; hardware reset restores all defaults, soft reset only far loopback
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlFive_r     <= CF_RESET;
      skewFrame_r    <= SK_RESET;
      strapLoad_r    <= 1'b1;
      regRdData_r    <= 16'h0000;
      eepSeen_r      <= 1'b0;
      carrierSense_r <= 1'b0;
    end else begin
      ctrlFive_r     <= ctrlFive_nxt;
      skewFrame_r    <= skewFrame_nxt;
      strapLoad_r    <= strapLoad_nxt;
      regRdData_r    <= rdData_nxt;
      eepSeen_r      <= eepSeen_nxt;
      carrierSense_r <= crsNxt;
    end
  end

  // outputs are bits of flip-flops
  assign xoverDisable_r = ctrlFive_r[CF_XOVER_BIT];
  assign lowPowerEn_r   = ctrlFive_r[CF_LOWPWR_BIT];
  assign amp100_r       = ctrlFive_r[CF_AMP100_LSB +: 3];
  assign amp1g_r        = ctrlFive_r[CF_AMP1G_LSB +: 3];
  assign edgeRate_r     = ctrlFive_r[CF_EDGE_LSB +: 3];
  assign farLoopback_r  = ctrlFive_r[CF_FARLB_BIT];
  assign txSkew_r       = skewFrame_r[SK_TX_LSB +: 2];
  assign rxSkew_r       = skewFrame_r[SK_RX_LSB +: 2];
  assign maxLenSel_r    = skewFrame_r[SK_JUMBO_LSB +: 2];
  assign noPreamble_r   = skewFrame_r[SK_NOPRE_BIT];

  // =====================================================================
  // checks
  property p_rsvd_read;
    @(posedge ref_clk) disable iff (!rstn)
      regRdEn && (regAddr == REG_RSVD_A || regAddr == REG_RSVD_B ||
                  regAddr == REG_RSVD_C) |=> regRdData_r == 16'h0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved register read nonzero");

  property p_xover_write;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_CTRL_FIVE
        |=> xoverDisable_r == $past(regWrData[15]);
  endproperty
  a_xover_write: assert property (p_xover_write)
    else $error("crossover bit not written");

  property p_crs_half;
    @(posedge ref_clk) disable iff (!rstn)
      !fullDuplex && !ctrlFive_r[13]
        |=> carrierSense_r == ($past(rxValid) | $past(txEnable));
  endproperty
  a_crs_half: assert property (p_crs_half)
    else $error("half duplex carrier wrong");

  property p_crs_full;
    @(posedge ref_clk) disable iff (!rstn)
      fullDuplex && ctrlFive_r[12] |=> !carrierSense_r;
  endproperty
  a_crs_full: assert property (p_crs_full)
    else $error("full duplex carrier not held low");

  property p_eep_read;
    @(posedge ref_clk) disable iff (!rstn)
      regRdEn && regAddr == REG_CTRL_FIVE
        |=> regRdData_r[11] == $past(eepSeen_r);
  endproperty
  a_eep_read: assert property (p_eep_read)
    else $error("eeprom present bit wrong");

  property p_amp_rsvd;
    @(posedge ref_clk) disable iff (!rstn)
      1'b1 |-> amp100_r != AMP_RESERVED && amp1g_r != AMP_RESERVED;
  endproperty
  a_amp_rsvd: assert property (p_amp_rsvd)
    else $error("reserved amplitude code stored");

  property p_strap_skew;
    @(posedge ref_clk) disable iff (!rstn)
      strapLoad_r |=> txSkew_r == $past(strapSkew) &&
                      rxSkew_r == $past(strapSkew);
  endproperty
  a_strap_skew: assert property (p_strap_skew)
    else $error("skew not loaded from straps");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_STRAP_SEL
        |=> $stable(skewFrame_r) && lowPowerEn_r == $past(lowPowerEn_r);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky field lost on soft reset");

  property p_len_write;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_SKEW_FRAME && !strapLoad_r
        |=> maxLenSel_r == $past(regWrData[11:10]) &&
            noPreamble_r == $past(regWrData[9]);
  endproperty
  a_len_write: assert property (p_len_write)
    else $error("length or preamble field not written");

  // =====================================================================
  // field checks; each field but far loopback and the carrier control is pinned to the
  // write that set it, so a slipped mask bit shows at once rather than in a later read
  property p_rd_idle;
    @(posedge ref_clk) disable iff (!rstn)
      !regRdEn |=> regRdData_r == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data left standing");

  property p_rsvd_write;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && !strapLoad_r && (regAddr == REG_RSVD_A ||
        regAddr == REG_RSVD_B || regAddr == REG_RSVD_C)
        |=> $stable(ctrlFive_r) && $stable(skewFrame_r);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("reserved register write changed state");

  property p_ro_read;
    @(posedge ref_clk) disable iff (!rstn)
      regRdEn && regAddr == REG_SKEW_FRAME
        |=> regRdData_r[8:0] == 9'h000;
  endproperty
  a_ro_read: assert property (p_ro_read)
    else $error("reserved skew bits read nonzero");

  property p_lowpwr_write;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_CTRL_FIVE
        |=> lowPowerEn_r == $past(regWrData[CF_LOWPWR_BIT]);
  endproperty
  a_lowpwr_write: assert property (p_lowpwr_write)
    else $error("reduced power bit not written");

  property p_amp100_write;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_CTRL_FIVE &&
      regWrData[CF_AMP100_LSB +: 3] != AMP_RESERVED
        |=> amp100_r == $past(regWrData[CF_AMP100_LSB +: 3]);
  endproperty
  a_amp100_write: assert property (p_amp100_write)
    else $error("100M amplitude not written");

  // a reserved code must not disturb the setting already in use
  property p_amp100_keep;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_CTRL_FIVE &&
      regWrData[CF_AMP100_LSB +: 3] == AMP_RESERVED
        |=> $stable(amp100_r);
  endproperty
  a_amp100_keep: assert property (p_amp100_keep)
    else $error("100M amplitude changed by reserved code");

  property p_amp1g_write;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_CTRL_FIVE &&
      regWrData[CF_AMP1G_LSB +: 3] != AMP_RESERVED
        |=> amp1g_r == $past(regWrData[CF_AMP1G_LSB +: 3]);
  endproperty
  a_amp1g_write: assert property (p_amp1g_write)
    else $error("gigabit amplitude not written");

  property p_amp1g_keep;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_CTRL_FIVE &&
      regWrData[CF_AMP1G_LSB +: 3] == AMP_RESERVED
        |=> $stable(amp1g_r);
  endproperty
  a_amp1g_keep: assert property (p_amp1g_keep)
    else $error("gigabit amplitude changed by reserved code");

  property p_edge_write;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_CTRL_FIVE
        |=> edgeRate_r == $past(regWrData[CF_EDGE_LSB +: 3]);
  endproperty
  a_edge_write: assert property (p_edge_write)
    else $error("edge rate not written");

  property p_crs_rxonly;
    @(posedge ref_clk) disable iff (!rstn)
      !fullDuplex && ctrlFive_r[CF_CRS_LSB + 1]
        |=> carrierSense_r == $past(rxValid);
  endproperty
  a_crs_rxonly: assert property (p_crs_rxonly)
    else $error("half duplex carrier not rx valid alone");

  property p_crs_fullrx;
    @(posedge ref_clk) disable iff (!rstn)
      fullDuplex && !ctrlFive_r[CF_CRS_LSB]
        |=> carrierSense_r == $past(rxValid);
  endproperty
  a_crs_fullrx: assert property (p_crs_fullrx)
    else $error("full duplex carrier not rx valid");

  // a write in the strap cycle still wins, so no strap guard here
  property p_skew_write;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_SKEW_FRAME
        |=> txSkew_r == $past(regWrData[SK_TX_LSB +: 2]) &&
            rxSkew_r == $past(regWrData[SK_RX_LSB +: 2]);
  endproperty
  a_skew_write: assert property (p_skew_write)
    else $error("skew fields not written");

  property p_soft_clear;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == REG_STRAP_SEL && regWrData[SR_SOFT_BIT]
        |=> !farLoopback_r;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("soft reset left far loopback set");
endmodule

// File: core/pxc_pkg.sv
package pxc_pkg;
  // =====================================================================
  // register indices (management register numbers)
  localparam logic [4:0] REG_RSVD_A     = 5'h18;
  localparam logic [4:0] REG_RSVD_B     = 5'h19;
  localparam logic [4:0] REG_RSVD_C     = 5'h1a;
  localparam logic [4:0] REG_CTRL_FIVE  = 5'h1b;
  localparam logic [4:0] REG_SKEW_FRAME = 5'h1c;
  localparam logic [4:0] REG_STRAP_SEL  = 5'h1f;
  // =====================================================================
  // control five fields
  localparam int CF_XOVER_BIT   = 15;
  localparam int CF_CRS_LSB     = 12;
  localparam int CF_EEP_BIT     = 11;
  localparam int CF_FARLB_BIT   = 10;
  localparam int CF_LOWPWR_BIT  = 9;
  localparam int CF_AMP100_LSB  = 6;
  localparam int CF_AMP1G_LSB   = 3;
  localparam int CF_EDGE_LSB    = 0;
  localparam logic [15:0] CF_RW_MASK = 16'hb7ff;
  localparam logic [15:0] CF_RESET   = 16'h8187;
  // =====================================================================
  // skew and frame fields
  localparam int SK_TX_LSB      = 14;
  localparam int SK_RX_LSB      = 12;
  localparam int SK_JUMBO_LSB   = 10;
  localparam int SK_NOPRE_BIT   = 9;
  localparam logic [15:0] SK_RW_MASK = 16'hfe00;
  localparam logic [15:0] SK_RESET   = 16'h0000;
  // =====================================================================
  // reserved code of both amplitude fields
  localparam logic [2:0] AMP_RESERVED = 3'h3;
  // =====================================================================
  // software reset control register (own)
  localparam int SR_SOFT_BIT = 0;
endpackage

// File: core/pxc_crs_mux.sv
module pxc_crs_mux
  import pxc_pkg::*;
(
  // mac side
  input  wire logic       rxValid,
  input  wire logic       txEnable,
  input  wire logic       fullDuplex,
  // control
  input  wire logic [1:0] crsCtrl,
  // result
  output logic            crsNxt
);
  always_comb begin
    if (fullDuplex) begin
      crsNxt = crsCtrl[0] ? 1'b0 : rxValid;
    end else begin
      crsNxt = crsCtrl[1] ? rxValid : (rxValid | txEnable);
    end
  end
endmodule

// File: verification/pxc_mac_model.sv
// =====================================================================
// mac side partner: drives receive valid, transmit enable and duplex
module pxc_mac_model (
  // clock
  input  wire logic       ref_clk,
  // command from the bench {duplex, rx valid, tx enable}
  input  wire logic [2:0] cmd,
  // mac lines
  output logic            rxValid,
  output logic            txEnable,
  output logic            fullDuplex
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines move only just after an edge, as a real mac launches them
  always_ff @(posedge ref_clk) begin
    {fullDuplex, rxValid, txEnable} <= cmd;
  end
endmodule

// File: verification/pxc_ext_bank_tb_top.sv
// =====================================================================
// bench for the extended control bank
module pxc_ext_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pxc_pkg::*;
  logic ref_clk, rstn, wrEn, rdEn, eep, rxV, txE, fd, crs, xo, lp, nop, flb;
  logic [4:0]  addr;
  logic [15:0] wdata, rdData;
  logic [2:0]  cmd, a100, a1g, edg;
  logic [1:0]  strap, txs, rxs, mls;
  int miscompares, check_count, cycles;
  pxc_mac_model u_mac (.ref_clk(ref_clk), .cmd(cmd), .rxValid(rxV),
    .txEnable(txE), .fullDuplex(fd));
  pxc_ext_bank u_dut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(addr),
    .regWrData(wdata), .regWrEn(wrEn), .regRdEn(rdEn), .regRdData_r(rdData),
    .eepromDetected(eep), .strapSkew(strap), .fullDuplex(fd), .rxValid(rxV),
    .txEnable(txE), .carrierSense_r(crs), .xoverDisable_r(xo),
    .lowPowerEn_r(lp), .amp100_r(a100), .amp1g_r(a1g), .edgeRate_r(edg),
    .txSkew_r(txs), .rxSkew_r(rxs), .maxLenSel_r(mls), .noPreamble_r(nop),
    .farLoopback_r(flb));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wrEn <= 1'b1;
    @(posedge ref_clk);
    wrEn <= 1'b0;
  endtask
  // read data stand one cycle only, then fall back to zero
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    addr <= a; rdEn <= 1'b1;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1 chk(rdData, exp);
    @(posedge ref_clk);
    #1 chk(rdData, 16'h0000);
  endtask
  task automatic t_reset;
    rd(5'h1b, 16'h8187);
    chk({xo, lp, a100, a1g, edg}, {1'b1, 1'b0, 9'h187});
    rd(5'h1c, {strap, strap, 12'h000});
  endtask
  task automatic t_fields;
    wr(5'h1b, 16'hffff);
    rd(5'h1b, 16'hb7ff);
    chk({xo, lp, a100, a1g, edg}, 16'h07ff);
    wr(5'h1c, 16'h0e00);
    #1 chk({txs, rxs, mls, nop}, 16'h0007);
    eep <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(5'h1b, 16'hbfff);
    eep <= 1'b0;
  endtask
  // soft reset clears only the far loopback bit
  task automatic t_soft;
    wr(5'h1c, 16'hfe00);
    wr(5'h1f, 16'h0001);
    rd(5'h1b, 16'hb3ff);
    rd(5'h1c, 16'hfe00);
    chk({flb, txs, rxs, mls, nop}, 16'h007f);
  endtask
  task automatic t_amp;
    wr(5'h1b, 16'h00c8);
    rd(5'h1b, 16'h01c8);
    wr(5'h1b, 16'h0018);
    rd(5'h1b, 16'h0008);
  endtask
  // mid-run hardware reset brings every sticky field back to default
  task automatic t_hwrst;
    @(posedge ref_clk);
    rstn <= 1'b0;
    strap <= 2'h1;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(5'h1b, 16'h8187);
    rd(5'h1c, 16'h5000);
  endtask
  task automatic t_rsvd;
    logic [4:0] a;
    for (a = 5'h18; a <= 5'h1a; a++) begin
      wr(a, 16'hffff);
      rd(a, 16'h0000);
    end
  endtask
  task automatic t_crs;
    logic exp;
    for (int c = 0; c < 4; c++) begin
      wr(5'h1b, 16'(c << 12));
      for (int k = 0; k < 8; k++) begin
        @(posedge ref_clk);
        cmd <= 3'(k);
        repeat (2) @(posedge ref_clk);
        exp = k[2] ? (c[0] ? 1'b0 : k[1]) : (c[1] ? k[1] : k[1] | k[0]);
        #1 chk({15'h0000, crs}, {15'h0000, exp});
      end
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // a hung run is cut short well beyond the expected length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    rstn = 1'b0; wrEn = 1'b0; rdEn = 1'b0; eep = 1'b0; cmd = 3'h0;
    addr = 5'h00; wdata = 16'h0000; strap = 2'h2;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    // first edge after release loads the straps
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_fields();
    t_soft();
    t_amp();
    t_rsvd();
    t_crs();
    t_hwrst();
    test_done();
  end
endmodule
